// *** bench/gir_host.sv ***
/*
  gir_host: APB master model standing in for host software.
  Assumes gir_top answers on pclk with pready_q, prdata_q and pslverr_q.
*/
`timescale 1ns/1ps
module gir_host
(
  input  wire logic             pclk,
  input  wire logic             pready_q,
  input  wire logic             pslverr_q,
  input  wire logic [31:0]      prdata_q,
  output gir_pkg::gir_apb_req_s apb_req
);
  import gir_pkg::*;
  initial apb_req = '0;
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (pready_q !== 1'b1);
    r = prdata_q;
    err = pslverr_q;
    // released lines show the inverse so a stale value cannot pass for a held one
    apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
  endtask
endmodule

// *** bench/gir_top_props.sv ***
/*
  gir_top_props: bus and routing checks on the ports of gir_top.
  Assumes one clock pclk and the asynchronous active-low reset presetn.
*/
`timescale 1ns/1ps
module gir_top_props
(
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire gir_pkg::gir_apb_req_s       apb_req,
  input wire logic [31:0]                 prdata_q,
  input wire logic                        pready_q,
  input wire logic                        pslverr_q,
  input wire logic [gir_pkg::NUM_IN-1:0]  input_flag_q,
  input wire logic [gir_pkg::NUM_EVT-1:0] unlock_src_q,
  input wire logic                        event_valid_q,
  input wire gir_pkg::gir_event_s         event_q,
  input wire logic                        input_irq_flag_q
);
  import gir_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
  sequence s_access; apb_req.psel && apb_req.penable; endsequence
  // one wait state always, so the answer lands in the second access cycle
  property p_answer; s_setup ##1 s_access |=> pready_q; endproperty
  a_answer: assert property (p_answer) else $error("ready not after one wait state");
  property p_pulse; pready_q |=> !pready_q; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_inside; pready_q |-> s_access; endproperty
  a_inside: assert property (p_inside) else $error("ready outside an access");
  property p_err; pslverr_q |-> pready_q; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_err_data; pslverr_q && !apb_req.pwrite |-> prdata_q == 32'h0; endproperty
  a_err_data: assert property (p_err_data) else $error("refused read returned data");
  property p_resv; pready_q && !apb_req.pwrite && apb_req.paddr[9:2] == IDX_POL_HI
    |-> prdata_q[31:3] == 29'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved polarity bits set");
  property p_src; event_valid_q |-> !event_q.source[4] && unlock_src_q[event_q.source[3:0]];
  endproperty
  a_src: assert property (p_src) else $error("event from a source not routed");
  property p_route; $stable(unlock_src_q) |-> (input_flag_q[15:0] & unlock_src_q) == 16'h0;
  endproperty
  a_route: assert property (p_route) else $error("routed input raised its flag");
  property p_iirq; input_irq_flag_q |-> $past(|input_flag_q); endproperty
  a_iirq: assert property (p_iirq) else $error("input irq without a flag");
endmodule
bind gir_top gir_top_props props_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
  .input_flag_q(input_flag_q), .unlock_src_q(unlock_src_q), .event_valid_q(event_valid_q),
  .event_q(event_q), .input_irq_flag_q(input_irq_flag_q));

// *** bench/gir_top_tb.sv ***
/*
  gir_top_tb: directed checks of polarity, level flags and event routing.
  Assumes gir_host drives the APB side of gir_top.
*/
`timescale 1ns/1ps
module gir_top_tb;
  import gir_pkg::*;
  logic               pclk, presetn, pready_q, pslverr_q, event_valid_q;
  logic               input_irq_flag_q, irq_q;
  gir_apb_req_s       apb_req;
  logic [31:0]        prdata_q;
  logic [NUM_IN-1:0]  general_input, input_flag_q, pol;
  logic [NUM_EVT-1:0] unlock_src_q;
  gir_event_s         event_q;
  int                 fails, samples_checked, cycles, n;
  gir_top dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .general_input(general_input),
    .input_flag_q(input_flag_q), .unlock_src_q(unlock_src_q), .event_valid_q(event_valid_q),
    .event_q(event_q), .input_irq_flag_q(input_irq_flag_q), .irq_q(irq_q));
  gir_host host_u (.pclk(pclk), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .prdata_q(prdata_q), .apb_req(apb_req));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        x;
    host_u.xfer(1'b1, a, {24'h0, d}, r, x);
  endtask
  task automatic rd(input string s, input logic [9:0] a, input logic [31:0] e, input logic xe);
    logic [31:0] r;
    logic        x;
    host_u.xfer(1'b0, a, 32'h0, r, x);
    chk(s, e, r);
    chk(s, xe, x);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      finish_test();
    end
  end
  initial
  begin
    presetn = 1'b0;
    general_input = 19'h7ffff;
    fails = 0;
    samples_checked = 0;
    cycles = 0;
    settle(2);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd("reg_rst", 10'h078 + 10'(4 * i), 32'h0, 1'b0);
      wr(10'h078 + 10'(4 * i), 8'hff);
      rd("reg_rw", 10'h078+10'(4*i), (i == 2) ? 32'h07 : 32'hff, 1'b0);
    end
    // enables of inputs 9 to 19 are put back to zero before the level tests
    wr(10'h094, 8'hff);
    wr(10'h098, 8'hff);
    rd("ien_mid", 10'h094, 32'hff, 1'b0);
    rd("ien_hi", 10'h098, 32'h07, 1'b0);
    wr(10'h094, 8'h00);
    wr(10'h098, 8'h00);
    rd("unmapped", 10'h3fc, 32'h0, 1'b1);
    $display("test registers done");
    pol = 19'h5f00f;
    wr(10'h078, pol[7:0]);
    wr(10'h07c, pol[15:8]);
    wr(10'h080, {5'h0, pol[18:16]});
    wr(10'h084, 8'h00);
    wr(10'h088, 8'h00);
    wr(10'h090, 8'h01);
    wr(10'h0c0, 8'h01);
    general_input <= 19'h0f0a5;
    settle(6);
    chk("flags_a", {13'h0, ~(general_input ^ pol)}, input_flag_q);
    rd("flag_lo", 10'h0c4, {24'h0, ~(general_input[7:0] ^ pol[7:0])}, 1'b0);
    rd("flag_mid", 10'h0c8, {24'h0, ~(general_input[15:8] ^ pol[15:8])}, 1'b0);
    rd("flag_hi", 10'h0cc, {29'h0, ~(general_input[18:16] ^ pol[18:16])}, 1'b0);
    chk("in_irq", 32'h1, input_irq_flag_q);
    chk("irq_masked", 32'h0, irq_q);
    wr(10'h0c0, 8'h03);
    settle(2);
    chk("irq", 32'h1, irq_q);
    settle(20);
    chk("flags_hold", {13'h0, ~(general_input ^ pol)}, input_flag_q);
    general_input <= ~general_input;
    settle(6);
    chk("flags_b", {13'h0, ~(general_input ^ pol)}, input_flag_q);
    rd("status_in", 10'h004, 32'h2, 1'b0);
    rd("status_clr", 10'h004, 32'h0, 1'b0);
    settle(2);
    chk("irq_clr", 32'h0, irq_q);
    $display("test levels done");
    wr(10'h084, 8'h01);
    wr(10'h088, 8'h80);
    wr(10'h078, 8'h0e);
    settle(4);
    chk("unlock_src", 32'h8001, unlock_src_q);
    chk("routed_flags", 32'h0, input_flag_q & 19'h08001);
    chk("routed_irq", 32'h0, input_irq_flag_q);
    // input 2 is unrouted, so the first entry must come from input 16
    general_input <= general_input ^ 19'h08002;
    for (n = 0; n < 20 && event_valid_q !== 1'b1; n++) @(posedge pclk);
    chk("evt_seen", 32'h1, n < 20);
    chk("evt_src", 32'h0f, event_q.source);
    chk("evt_level", general_input[15], event_q.level);
    settle(2);
    chk("irq_evt", 32'h1, irq_q);
    rd("status_evt", 10'h004, 32'h1, 1'b0);
    $display("test events done");
    finish_test();
  end
endmodule

// *** hw/gir_input_sense.sv ***
/*
  gir_input_sense: registers the general inputs and flags every change.
  Assumes the inputs are already synchronous to pclk.
*/
`timescale 1ns/1ps
module gir_input_sense
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic [gir_pkg::NUM_IN-1:0] pins,
  output logic      [gir_pkg::NUM_IN-1:0] level_q,
  output logic      [gir_pkg::NUM_IN-1:0] change_q
);
  import gir_pkg::*;

  logic [NUM_IN-1:0] prev_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_q   <= '0;
      level_q  <= '0;
      change_q <= '0;
    end
    else
    begin
      prev_q   <= pins;
      level_q  <= prev_q;
      change_q <= prev_q ^ level_q;
    end
  end

endmodule

// *** hw/gir_pkg.sv ***
/*
  gir_pkg: constants and carrier types for the general input interrupt
  polarity and event routing block.
  Assumes a 32-bit APB master in the same clock domain as pclk.
*/
package gir_pkg;

  localparam int NUM_IN  = 19;
  localparam int NUM_EVT = 16;
  localparam int IDX_W   = 8;
  localparam int ADDR_W  = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STATUS   = 8'h01;
  localparam logic [IDX_W-1:0] IDX_POL_LO   = 8'h1e;
  localparam logic [IDX_W-1:0] IDX_POL_MID  = 8'h1f;
  localparam logic [IDX_W-1:0] IDX_POL_HI   = 8'h20;
  localparam logic [IDX_W-1:0] IDX_EVT_LO   = 8'h21;
  localparam logic [IDX_W-1:0] IDX_EVT_MID  = 8'h22;
  localparam logic [IDX_W-1:0] IDX_IEN_LO   = 8'h24;
  localparam logic [IDX_W-1:0] IDX_IEN_MID  = 8'h25;
  localparam logic [IDX_W-1:0] IDX_IEN_HI   = 8'h26;
  localparam logic [IDX_W-1:0] IDX_MASK     = 8'h30;
  localparam logic [IDX_W-1:0] IDX_FLAG_LO  = 8'h31;
  localparam logic [IDX_W-1:0] IDX_FLAG_MID = 8'h32;
  localparam logic [IDX_W-1:0] IDX_FLAG_HI  = 8'h33;

  // status and mask bit positions
  localparam int STAT_EVT_BIT   = 0;
  localparam int STAT_INPUT_BIT = 1;
  localparam int STAT_W         = 2;

  // only three inputs live in the high group
  localparam logic [7:0] HI_GROUP_MASK = 8'h07;

  // values after reset
  localparam logic [NUM_IN-1:0]  POL_RST    = 19'h00000;
  localparam logic [NUM_EVT-1:0] ROUTE_RST  = 16'h0000;
  localparam logic [NUM_IN-1:0]  IEN_RST    = 19'h00000;
  localparam logic [STAT_W-1:0]  MASK_RST   = 2'h0;
  localparam logic [31:0]        PRDATA_RST = 32'h00000000;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } gir_apb_req_s;

  // one event entry: input number counted from zero and its level
  typedef struct packed {
    logic [4:0] source;
    logic       level;
  } gir_event_s;

endpackage

// *** hw/gir_top.sv ***
/*
  gir_top: polarity selection and interrupt flags for nineteen general
  inputs, event routing for inputs 1 to 16, with an APB register slave.
  Assumes a synchronous APB master on pclk and an event FIFO and unlock
  logic downstream that consume the event pulse and source mask.
*/
//
// What this block does
// - polarity bit 0 means low pin is active, 1 means high pin is active
// - input 1 flag follows row pin zero level for as long as it holds
// - polarity register 0x1e holds inputs 1 to 8, input 8 in bit 7
// - polarity register 0x1f holds inputs 9 to 16, input 16 in bit 7
// - polarity register 0x20 holds inputs 17 to 19; bits 7 to 3 reserved
// - event route bit 1 makes input activity produce FIFO events; 0x21 inputs 1-8
// - event route register 0x22 covers inputs 9 to 16, input 16 in bit 7
// - routed inputs are FIFO event sources and valid unlock sources
// - activity on a routed input raises the FIFO event interrupt flag
// - a routed input never feeds the general input interrupt flag
// - input interrupt flag is status bit 1 of 0x01: flag, enable and level
`timescale 1ns/1ps
module gir_top
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire gir_pkg::gir_apb_req_s         apb_req,
  output logic      [31:0]                   prdata_q,
  output logic                               pready_q,
  output logic                               pslverr_q,
  input  wire logic [gir_pkg::NUM_IN-1:0]    general_input,
  output logic      [gir_pkg::NUM_IN-1:0]    input_flag_q,
  output logic      [gir_pkg::NUM_EVT-1:0]   unlock_src_q,
  output logic                               event_valid_q,
  output gir_pkg::gir_event_s                event_q,
  output logic                               input_irq_flag_q,
  output logic                               irq_q
);
  import gir_pkg::*;

  logic [NUM_IN-1:0]  level;
  logic [NUM_IN-1:0]  change;
  logic [NUM_IN-1:0]  pol_q;
  logic [NUM_EVT-1:0] route_q;
  logic [NUM_IN-1:0]  ien_q;
  logic [STAT_W-1:0]  mask_q;
  logic [STAT_W-1:0]  status_q;
  logic [NUM_EVT-1:0] pend_q;

  gir_input_sense u_sense
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .pins     (general_input),
    .level_q  (level),
    .change_q (change)
  );

  // apb slave: one wait state, answer registered
  wire                 acc_start = apb_req.psel & apb_req.penable & ~pready_q;
  wire                 acc_done  = apb_req.psel & apb_req.penable & pready_q;
  wire [IDX_W-1:0]     idx       = apb_req.paddr[ADDR_W-1:2];
  wire                 wr_done   = acc_done & apb_req.pwrite;
  wire                 rd_done   = acc_done & ~apb_req.pwrite;
  wire [7:0]           wbyte     = apb_req.pwdata[7:0];

  wire sel_status   = (idx == IDX_STATUS);
  wire sel_pol_lo   = (idx == IDX_POL_LO);
  wire sel_pol_mid  = (idx == IDX_POL_MID);
  wire sel_pol_hi   = (idx == IDX_POL_HI);
  wire sel_evt_lo   = (idx == IDX_EVT_LO);
  wire sel_evt_mid  = (idx == IDX_EVT_MID);
  wire sel_ien_lo   = (idx == IDX_IEN_LO);
  wire sel_ien_mid  = (idx == IDX_IEN_MID);
  wire sel_ien_hi   = (idx == IDX_IEN_HI);
  wire sel_mask     = (idx == IDX_MASK);
  wire sel_flag_lo  = (idx == IDX_FLAG_LO);
  wire sel_flag_mid = (idx == IDX_FLAG_MID);
  wire sel_flag_hi  = (idx == IDX_FLAG_HI);

  wire hit = sel_status | sel_pol_lo | sel_pol_mid | sel_pol_hi | sel_evt_lo
           | sel_evt_mid | sel_ien_lo | sel_ien_mid | sel_ien_hi | sel_mask
           | sel_flag_lo | sel_flag_mid | sel_flag_hi;

  wire [7:0] hi_pol_rd  = {5'h00, pol_q[18:16]};
  wire [7:0] hi_ien_rd  = {5'h00, ien_q[18:16]};
  wire [7:0] hi_flag_rd = {5'h00, input_flag_q[18:16]};

  wire [7:0] rd_byte =
      sel_status   ? {6'h00, status_q}     :
      sel_pol_lo   ? pol_q[7:0]            :
      sel_pol_mid  ? pol_q[15:8]           :
      sel_pol_hi   ? hi_pol_rd             :
      sel_evt_lo   ? route_q[7:0]          :
      sel_evt_mid  ? route_q[15:8]         :
      sel_ien_lo   ? ien_q[7:0]            :
      sel_ien_mid  ? ien_q[15:8]           :
      sel_ien_hi   ? hi_ien_rd             :
      sel_mask     ? {6'h00, mask_q}       :
      sel_flag_lo  ? input_flag_q[7:0]     :
      sel_flag_mid ? input_flag_q[15:8]    :
      sel_flag_hi  ? hi_flag_rd            :
                     8'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= PRDATA_RST;
    end
    else
    begin
      pready_q  <= acc_start;
      pslverr_q <= acc_start & ~hit;
      if (acc_start)
      begin
        prdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  // configuration registers
  wire [NUM_IN-1:0] pol_d =
      {(wr_done & sel_pol_hi)  ? wbyte[2:0] : pol_q[18:16],
       (wr_done & sel_pol_mid) ? wbyte      : pol_q[15:8],
       (wr_done & sel_pol_lo)  ? wbyte      : pol_q[7:0]};

  wire [NUM_EVT-1:0] route_d =
      {(wr_done & sel_evt_mid) ? wbyte : route_q[15:8],
       (wr_done & sel_evt_lo)  ? wbyte : route_q[7:0]};

  wire [NUM_IN-1:0] ien_d =
      {(wr_done & sel_ien_hi)  ? wbyte[2:0] : ien_q[18:16],
       (wr_done & sel_ien_mid) ? wbyte      : ien_q[15:8],
       (wr_done & sel_ien_lo)  ? wbyte      : ien_q[7:0]};

  wire [STAT_W-1:0] mask_d = (wr_done & sel_mask) ? wbyte[STAT_W-1:0] : mask_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pol_q   <= POL_RST;
      route_q <= ROUTE_RST;
      ien_q   <= IEN_RST;
      mask_q  <= MASK_RST;
    end
    else
    begin
      pol_q   <= pol_d;
      route_q <= route_d;
      ien_q   <= ien_d;
      mask_q  <= mask_d;
    end
  end

  // level flags and the general input interrupt
  // inputs 17 to 19 have no route bit here, so they always stay in
  // interrupt mode
  wire [NUM_IN-1:0] route_full = {3'h0, route_q};

  // active when the pin equals its polarity bit, for as long as it does
  wire [NUM_IN-1:0] level_cond = ~(level ^ pol_q);

  // a routed input is masked out regardless of enable or polarity
  wire [NUM_IN-1:0] flag_d = level_cond & ~route_full;

  wire input_irq_d = |(input_flag_q & ien_q);

  // event selection: lowest pending routed input goes first
  logic [NUM_EVT:0]   lower_any;
  logic [NUM_EVT-1:0] grant;

  assign lower_any[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi++)
    begin : g_pick
      assign grant[gi]       = pend_q[gi] & ~lower_any[gi];
      assign lower_any[gi+1] = lower_any[gi] | pend_q[gi];
    end
  endgenerate

  function automatic logic [4:0] encode(input logic [NUM_EVT-1:0] onehot);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < NUM_EVT; i++)
    begin
      if (onehot[i])
      begin
        n = 5'(i);
      end
    end
    return n;
  endfunction

  wire        any_grant  = lower_any[NUM_EVT];
  wire [4:0]  grant_num  = encode(grant);

  // a change in the same cycle as its grant is kept pending, so a
  // fast toggle produces a second entry instead of being lost
  wire [NUM_EVT-1:0] pend_d = (pend_q & ~grant)
                            | (change[NUM_EVT-1:0] & route_q);

  // sticky status, cleared by reading it
  // only the bits actually returned are cleared, so a set that lands
  // after the read data was captured survives
  wire [STAT_W-1:0] rd_clear = (rd_done & sel_status) ? prdata_q[STAT_W-1:0]
                                                      : {STAT_W{1'b0}};
  wire [STAT_W-1:0] stat_set;

  assign stat_set[STAT_EVT_BIT]   = any_grant;
  assign stat_set[STAT_INPUT_BIT] = input_irq_d;

  wire [STAT_W-1:0] status_d = (status_q & ~rd_clear) | stat_set;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_flag_q     <= '0;
      pend_q           <= '0;
      status_q         <= '0;
      input_irq_flag_q <= 1'b0;
      irq_q            <= 1'b0;
      event_valid_q    <= 1'b0;
      event_q          <= '0;
      unlock_src_q     <= '0;
    end
    else
    begin
      input_flag_q     <= flag_d;
      pend_q           <= pend_d;
      status_q         <= status_d;
      input_irq_flag_q <= input_irq_d;
      irq_q            <= |(status_d & mask_q);
      event_valid_q    <= any_grant;
      event_q.source   <= grant_num;
      event_q.level    <= |(grant & level[NUM_EVT-1:0]);
      unlock_src_q     <= route_q;
    end
  end

endmodule
